// File: logic/dsp_pkg.sv
package dsp_pkg;
	// Word widths and frame shape
	localparam int ACCEL_W = 12;
	localparam int TEMP_W = 10;
	localparam int CTRL_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] SAMPLE_EDGE = 4'h1;
	localparam logic [3:0] CTRL_LAST_EDGE = 4'h7;
	localparam logic [3:0] WAKE_EDGE = 4'hf;
	localparam logic [3:0] LAST_FALL = 4'hf;
	localparam logic [3:0] ACCEL_LEAD_ZEROS = 4'h0;
	// Control byte layout
	localparam int CTRL_POWER_DOWN_BIT = 0;
	localparam int CTRL_AXIS_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h04;
	// Acceleration code points, one step per 1/256 g
	localparam logic [11:0] ACCEL_ZERO = 12'h800;
	localparam logic [11:0] ACCEL_POS_FS = 12'hd00;
	localparam logic [11:0] ACCEL_NEG_FS = 12'h300;
	localparam logic [11:0] SELF_TEST_STEP = 12'h0cd;
	// Temperature autoconversion interval
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TEMP_PERIOD_US = 350;
	localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_US * 1000000 / CLK_PERIOD_PS;
	localparam logic [9:0] TEMP_RESET = 10'h000;
	// Accelerometer power state
	typedef enum logic [1:0]
	{
		DSP_RUN = 2'b00,
		DSP_SHUT = 2'b01,
		DSP_WAKE = 2'b10
	} dsp_mode_e;
endpackage

// File: logic/dsp_fifo_if.sv
`timescale 1ns/1ps
interface dsp_fifo_if #(parameter int WIDTH = 12);
	logic wrValid;
	logic wrReady;
	logic [WIDTH-1:0] wrData;
	logic rdValid;
	logic rdReady;
	logic [WIDTH-1:0] rdData;
	modport fifo (input wrValid, input wrData, output wrReady,
		output rdValid, output rdData, input rdReady);
	modport user (output wrValid, output wrData, input wrReady,
		input rdValid, input rdData, output rdReady);
endinterface // dsp_fifo_if

// File: logic/dsp_fifo.sv
`timescale 1ns/1ps
module dsp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	dsp_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	wire push = port.wrValid && port.wrReady;
	wire pop = port.rdValid && port.rdReady;

	// Honest flags straight from the occupancy count
	assign port.wrReady = (count != (AW+1)'(DEPTH));
	assign port.rdValid = (count != '0);
	assign port.rdData = mem[rdPtr];

	// Storage written only on accepted pushes
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr] <= port.wrData;
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + AW'(1);
			if (pop)
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + AW'(1);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // dsp_fifo

// File: logic/dsp_serial_port.sv
`timescale 1ns/1ps
// Functional notes
// - Low temp select frames one temperature read
// - Data out changes on serial clock falls
// - Control bits captured on serial clock rises
// - Accel select fall starts conversion and frame
// - Serial clock paces the acceleration conversion
// - Result is 12-bit offset binary, zero 0x800
// - Sample taken on second rise after select
// - Conversion spans sixteen serial clocks
// - Accel select rise releases data out unless temp select is low
// - Held select starts next conversion automatically
// - Control bit 3 picks x or y
// - Control bit 0 enters power-down immediately
// - Control contents kept while shut down
// - Wake-up takes effect on sixteenth rise
// - Temp port ignores clocks unless selected
// - Temp read: leading zero, ten bits
// - Last temp bit held until select rises
// - Temperature is two's complement quarter degrees
// - Temperature autoconverts every 350 us
module dsp_serial_port #(
	parameter int TEMP_PERIOD = dsp_pkg::TEMP_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic accelSelN,
	input wire logic temp_select_n,
	input wire logic din,
	input wire logic self_test_in,
	input wire logic [dsp_pkg::ACCEL_W-1:0] accelX,
	input wire logic [dsp_pkg::ACCEL_W-1:0] accelY,
	input wire logic [dsp_pkg::TEMP_W-1:0] tempIn,
	output logic dout,
	output logic doutOe,
	output logic powerDown
);
	import dsp_pkg::*;

	logic [2:0] sclkS;
	logic [2:0] accelSelS;
	logic [1:0] tempSelS;
	logic [1:0] dinS;
	logic [1:0] selfTestS;
	logic [ACCEL_W-1:0] accelXS [2];
	logic [ACCEL_W-1:0] accelYS [2];
	logic [TEMP_W-1:0] tempS [2];
	logic [3:0] riseCount;
	logic [3:0] fallCount;
	logic [CTRL_W-2:0] ctrlShift;
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] pendingCtrl;
	dsp_mode_e mode;
	logic pendValid;
	logic [ACCEL_W-1:0] pendData;
	logic [ACCEL_W-1:0] dataWord;
	logic [TEMP_W-1:0] tempReg;
	logic [TEMP_W-1:0] tempWord;
	logic [16:0] tempTimer;
	logic tempFrameD;
	logic next_dout;

	dsp_fifo_if #(.WIDTH(ACCEL_W)) sampleQ ();

	dsp_fifo #(.WIDTH(ACCEL_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.port(sampleQ.fifo)
	);

	// Two-flop synchronisers; first stages feed only second stages
	always_ff @(posedge clk)
	begin
		sclkS <= {sclkS[1:0], sclk};
		accelSelS <= {accelSelS[1:0], accelSelN};
		tempSelS <= {tempSelS[0], temp_select_n};
		dinS <= {dinS[0], din};
		selfTestS <= {selfTestS[0], self_test_in};
		accelXS <= '{accelX, accelXS[0]};
		accelYS <= '{accelY, accelYS[0]};
		tempS <= '{tempIn, tempS[0]};
	end

	// Edge and frame decode on synchronised levels; accel wins if both are low
	wire sclkRise = sclkS[1] && !sclkS[2];
	wire sclkFall = !sclkS[1] && sclkS[2];
	wire accelFrame = !accelSelS[1];
	wire accelStart = !accelSelS[1] && accelSelS[2];
	wire tempFrame = !tempSelS[1] && !accelFrame;
	wire frameActive = accelFrame || tempFrame;
	wire ctrlWrite = accelFrame && sclkRise && (riseCount == CTRL_LAST_EDGE);
	wire wakeEdge = accelFrame && sclkRise && (riseCount == WAKE_EDGE);
	wire [CTRL_W-1:0] newByte = {ctrlShift, dinS[1]};
	wire tempHold = tempFrame && (fallCount == LAST_FALL);

	// Edge counters only run inside a frame; an idle bus has no effect
	always_ff @(posedge clk)
	begin
		if (rst || !frameActive || accelStart)
		begin
			riseCount <= '0;
			fallCount <= '0;
		end
		else
		begin
			if (sclkRise)
				riseCount <= riseCount + 4'h1;
			if (sclkFall && !tempHold)
				fallCount <= fallCount + 4'h1;
		end
	end

	// Control byte arrives MSB first over the first eight rises
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrlShift <= '0;
		else if (accelFrame && sclkRise && riseCount < CTRL_LAST_EDGE)
			ctrlShift <= {ctrlShift[CTRL_W-3:0], dinS[1]};
	end

	// Power state; in shutdown a wake byte waits for the 16th rise
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode <= DSP_RUN;
			ctrl <= CTRL_RESET;
			pendingCtrl <= CTRL_RESET;
		end
		else
		begin
			case (mode)
				DSP_RUN:
				begin
					if (ctrlWrite)
					begin
						ctrl <= newByte;
						if (newByte[CTRL_POWER_DOWN_BIT])
							mode <= DSP_SHUT;
					end
				end
				DSP_SHUT:
				begin
					if (ctrlWrite && !newByte[CTRL_POWER_DOWN_BIT])
					begin
						pendingCtrl <= newByte;
						mode <= DSP_WAKE;
					end
				end
				DSP_WAKE:
				begin
					if (wakeEdge)
					begin
						ctrl <= pendingCtrl;
						mode <= DSP_RUN;
					end
					else if (!accelFrame)
						mode <= DSP_SHUT;
				end
				default:
					mode <= DSP_RUN;
			endcase
		end
	end

	// Sample the chosen axis at the second rise, not while shut down
	wire sampleTake = accelFrame && sclkRise && (riseCount == SAMPLE_EDGE)
		&& (mode == DSP_RUN);
	wire [ACCEL_W-1:0] axisValue = ctrl[CTRL_AXIS_BIT] ? accelYS[1] : accelXS[1];
	wire [ACCEL_W-1:0] sampleValue = selfTestS[1] ? axisValue + SELF_TEST_STEP : axisValue;

	// Pending slot holds a sample until the FIFO takes it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pendValid <= 1'b0;
			pendData <= ACCEL_ZERO;
		end
		else if (sampleTake)
		begin
			pendValid <= 1'b1;
			pendData <= sampleValue;
		end
		else if (sampleQ.wrReady)
			pendValid <= 1'b0;
	end

	assign sampleQ.wrValid = pendValid;
	assign sampleQ.wrData = pendData;
	// Drain only after this frame's sample point, so nothing stale is shown
	assign sampleQ.rdReady = accelFrame && (riseCount > SAMPLE_EDGE);

	// Output word cleared at each frame start; shutdown frames read zero
	always_ff @(posedge clk)
	begin
		if (rst || accelStart)
			dataWord <= '0;
		else if (sampleQ.rdValid && sampleQ.rdReady)
			dataWord <= sampleQ.rdData;
	end

	// Temperature timer; an expiry during a read is locked out
	wire tempExpire = (tempTimer == 17'(TEMP_PERIOD - 1));
	always_ff @(posedge clk)
	begin
		tempFrameD <= rst ? 1'b0 : tempFrame;
		if (rst || tempExpire || (tempFrameD && !tempFrame))
			tempTimer <= '0;
		else
			tempTimer <= tempTimer + 17'h1;
		if (rst)
			tempReg <= TEMP_RESET;
		else if (tempExpire && !tempFrame)
			tempReg <= tempS[1];
		if (rst)
			tempWord <= TEMP_RESET;
		else if (!tempFrame)
			tempWord <= tempReg;
	end

	// Bit select; the temperature tail repeats its last bit
	wire [15:0] accelOut = {ACCEL_LEAD_ZEROS, dataWord};
	wire [15:0] tempOut = {1'b0, tempWord, {5{tempWord[0]}}};
	wire [3:0] bitIdx = LAST_FALL - fallCount;
	always_comb
	begin
		next_dout = 1'b0;
		if (accelFrame)
			next_dout = accelOut[bitIdx];
		else if (tempFrame)
			next_dout = tempOut[bitIdx];
	end

	// Pin drivers registered; released as soon as no select is low
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dout <= 1'b0;
			doutOe <= 1'b0;
			powerDown <= 1'b0;
		end
		else
		begin
			dout <= next_dout;
			doutOe <= frameActive;
			powerDown <= (mode != DSP_RUN);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_oe_frame;
		doutOe == $past(frameActive);
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("driver enable off frame");

	property p_release;
		$rose(accelSelS[1]) && tempSelS[1] |=> !doutOe;
	endproperty
	a_release: assert property (p_release) else $error("driver not released");

	property p_dout_fall;
		accelFrame && $past(accelFrame, 3) && $changed(dout) |-> $past(sclkFall, 2);
	endproperty
	a_dout_fall: assert property (p_dout_fall) else $error("data changed off a fall");

	property p_sample;
		sampleTake |=> pendValid && pendData == $past(sampleValue) && riseCount == 4'h2;
	endproperty
	a_sample: assert property (p_sample) else $error("sample not captured");

	property p_pd_enter;
		ctrlWrite && mode == DSP_RUN && newByte[CTRL_POWER_DOWN_BIT] |=> ##1 powerDown;
	endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

	property p_shut_hold;
		mode != DSP_RUN && !wakeEdge |=> $stable(ctrl);
	endproperty
	a_shut_hold: assert property (p_shut_hold) else $error("control changed in shutdown");

	property p_wake;
		mode == DSP_WAKE && wakeEdge |=> mode == DSP_RUN && ctrl == $past(pendingCtrl);
	endproperty
	a_wake: assert property (p_wake) else $error("wake not on last rise");

	property p_idle;
		!frameActive |=> riseCount == 4'h0 && fallCount == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("counters moved outside frame");

	property p_wrap;
		accelFrame && sclkRise && riseCount == WAKE_EDGE && !accelStart |=> riseCount == 4'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("conversion did not restart");

	property p_temp_hold;
		tempHold && $past(tempHold) |-> dout == tempWord[0];
	endproperty
	a_temp_hold: assert property (p_temp_hold) else $error("temp tail not held");

	property p_temp_lead;
		$fell(tempSelS[1]) && accelSelS[1] |-> ##2 (doutOe && !dout);
	endproperty
	a_temp_lead: assert property (p_temp_lead) else $error("no leading zero");

	c_ctrl_write: cover property (ctrlWrite && mode == DSP_RUN);
	c_wake: cover property (mode == DSP_WAKE && wakeEdge);
	c_back_to_back: cover property (accelFrame && sclkRise && riseCount == WAKE_EDGE);
	c_temp_read: cover property ($past(tempHold) && $rose(tempSelS[1]));
endmodule // dsp_serial_port

// File: sim/dsp_host_model.sv
`timescale 1ns/1ps
// Host controller; serial clock idles high and runs between frames only in mode 2
module dsp_host_model (
	output logic sclk,
	output logic accelSelN,
	output logic temp_select_n,
	output logic din,
	input wire logic dout,
	input wire logic doutOe
);
	int oeBad;
	// No pull on the line; a released driver reads inverted so a late enable shows
	wire pinLevel = doutOe ? dout : !dout;
	// Idle levels at time zero
	initial
	begin
		sclk = 1'b1;
		accelSelN = 1'b1;
		temp_select_n = 1'b1;
		din = 1'b0;
		oeBad = 0;
	end
	// Mode 0 accel, 1 temp, 2 clocks with no select; nw words per frame
	// Frames run far above 10 kSPS; the digital axis codes have no filter to droop
	task automatic xfer(input int mode, input logic [7:0] ctrl, input int nw,
		output logic [31:0] got);
		got = '0;
		accelSelN = (mode != 0);
		temp_select_n = (mode != 1);
		// Quarter nanosecond keeps the 24 ns steps off the clk rising edge
		#40.25;
		for (int i = 0; i < 16 * nw; i++)
		begin
			// Sample just before the fall, the latest settled point
			got = {got[30:0], pinLevel};
			if (doutOe !== (mode != 2)) oeBad++;
			sclk = 1'b0;
			din = (mode == 0 && i % 16 < 8) ? ctrl[7 - i % 16] : 1'b0;
			#24;
			sclk = 1'b1;
			#24;
		end
		accelSelN = 1'b1;
		temp_select_n = 1'b1;
		#40;
		if (doutOe !== 1'b0) oeBad++;
	endtask
endmodule // dsp_host_model

// File: sim/test_dual_sensor_serial_port.sv
`timescale 1ns/1ps
module test_dual_sensor_serial_port;
	import dsp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk, accelSelN, temp_select_n, din, dout, doutOe, powerDown;
	logic st = 1'b0;
	logic [ACCEL_W-1:0] ax = ACCEL_POS_FS, ay = ACCEL_NEG_FS;
	logic [TEMP_W-1:0] tin = 10'h000;
	logic [31:0] got, e;
	logic [7:0] ctrl = CTRL_RESET;
	logic shut = 1'b0;
	int bad_count = 0, compares = 0;
	int seed = 32'h2814eab7;
	logic [11:0] q[$];
	// Clock
	always #2.5 clk = ~clk;
	dsp_serial_port #(.TEMP_PERIOD(200)) i_dsp_serial_port (.clk(clk), .rst(rst),
		.sclk(sclk), .accelSelN(accelSelN), .temp_select_n(temp_select_n), .din(din),
		.self_test_in(st), .accelX(ax), .accelY(ay), .tempIn(tin), .dout(dout),
		.doutOe(doutOe), .powerDown(powerDown));
	dsp_host_model i_dsp_host_model (.sclk(sclk), .accelSelN(accelSelN),
		.temp_select_n(temp_select_n), .din(din), .dout(dout), .doutOe(doutOe));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Accel frame; model samples with the old control byte, then applies the new one
	task automatic accel(input logic [7:0] c, input int nw, input logic s);
		@(posedge clk);
		#1;
		st = s;
		ax = 12'h300 + 12'($random(seed) & 32'h7ff);
		ay = 12'h300 + 12'($random(seed) & 32'h7ff);
		// One expected result per conversion, queued in frame order
		repeat (nw)
		begin
			q.push_back(shut ? 12'h000 : (ctrl[CTRL_AXIS_BIT] ? ay : ax)
				+ (st ? SELF_TEST_STEP : 12'h000));
			// Shutdown keeps the byte unless the write clears power-down
			if (!shut || !c[CTRL_POWER_DOWN_BIT])
			begin
				ctrl = c;
				shut = c[CTRL_POWER_DOWN_BIT];
			end
		end
		i_dsp_host_model.xfer(0, c, nw, got);
		e = '0;
		while (q.size() > 0)
			e = {e[15:0], 4'h0, q.pop_front()};
		chk("accel word", e, got);
		chk("power down", {31'h0, shut}, {31'h0, powerDown});
		$display("accel frame %h done", c);
	endtask
	// Temp frame after a pause; seen is the last completed conversion
	task automatic temp(input logic [9:0] t, input int pause, input logic [9:0] seen);
		@(posedge clk);
		#1;
		tin = t;
		repeat (pause) @(posedge clk);
		#1;
		i_dsp_host_model.xfer(1, 8'h00, 1, got);
		chk("temp word", {16'h0, 1'b0, seen, {5{seen[0]}}}, got);
		$display("temp frame %h done", t);
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("reset power down", 32'h0, {31'h0, powerDown});
		#1;
		i_dsp_host_model.xfer(2, 8'hff, 1, got);
		accel(8'h04, 1, 1'b0);
		accel(8'h0c, 1, 1'b0);
		accel(8'h8c, 2, 1'b1);
		accel(8'h05, 1, 1'b0);
		accel(8'h0d, 1, 1'b0);
		accel(8'h04, 1, 1'b0);
		accel(8'h04, 1, 1'b0);
		temp(10'h360, 300, 10'h360);
		temp(10'h064, 0, 10'h360);
		temp(10'h064, 300, 10'h064);
		chk("select framing", 32'h0, 32'(i_dsp_host_model.oeBad));
		// Sample buffer exercised through the pins: held selects, back to back
		accel(8'h0c, 2, 1'b0);
		accel(8'h04, 2, 1'b1);
		chk("select framing again", 32'h0, 32'(i_dsp_host_model.oeBad));
		$display("held frame test done");
		conclude();
	end
	// Watchdog; the whole run needs under 50 us
	initial
	begin
		#200000;
		bad_count++;
		$display("mismatch watchdog expected done seen hang");
		conclude();
	end
endmodule // test_dual_sensor_serial_port
